/* msi_sink.sv */
/*
 * Behavioural model of the host fabric that accepts message writes.
 * Assumes msiValid and msiWrite hold steady until the accepting edge.
 */
`timescale 1ns/100ps
module msi_sink (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic msiValid,
    input wire pci_pm_msi_pkg::msi_wr_s msiWrite,
    input wire logic [3:0] stall,
    output logic msiReady,
    output int count,
    output pci_pm_msi_pkg::msi_wr_s lastWrite
);
    // ------------------------------------------------------------
    // Accept after the programmed stall and record the write.
    // ------------------------------------------------------------
    logic [3:0] waitCnt;

    always @(posedge ref_clk) begin
        if (!reset_n) begin
            msiReady <= 1'b0;
            count <= 0;
            waitCnt <= 4'h0;
            lastWrite <= '0;
        end else if (msiValid && msiReady) begin
            msiReady <= 1'b0;
            count <= count + 1;
            lastWrite <= msiWrite;
            waitCnt <= 4'h0;
        end else if (msiValid && waitCnt >= stall) begin
            msiReady <= 1'b1;
        end else if (msiValid) begin
            waitCnt <= waitCnt + 4'h1;
        end
    end
endmodule : msi_sink

/* pci_pm_msi_capability.sv */
/*
 * Power state control and message signaled interrupt capability of one
 * function, with the message write launcher and the legacy pin.
 * Assumes the configuration requester holds no request while an answer
 * is pending and that the auxiliary control bit is on ref_clk.
 */
//
// Contract
// - Power state field is writable and reads back; 00 on, 11 hot low-power.
// - Writes of 10 or 01 to power state are discarded.
// - In hot low-power: config answered, I/O and memory refused, interrupts blocked; a message write launched before entry still completes.
// - Suppress bit 1: low-power to on keeps all configuration context.
// - Suppress bit 0: low-power to on performs internal reset of context.
// - Suppress bit is read-only and mirrors auxiliary control bit 6.
// - Wake enable and wake status read 0; writes do nothing.
// - Capability header reads identifier 05h and next pointer 00h.
// - An interrupt is one dword memory write to programmed address with data.
// - With message enable set, the legacy interrupt pin is not used.
// - Wide-address-capable bit reads constant 1.
// - Multi-message enable stores writes; one message only; capable field reads 000b.
// - Low address stores bits 31:2; bits 1:0 read 00b.
// - Upper address keeps bits 3:0 writable; bits 31:4 read zero.
// - Programmed data goes on lower 16 bits of each message write.
// - Message registers reset on host reset and low-power to on.
// - That transition resets them only while the suppress bit reads 0.
`timescale 1ns/100ps
module pci_pm_msi_capability (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic cfgValid,
    input wire pci_pm_msi_pkg::cfg_req_s cfgReq,
    output logic cfgAck,
    output logic [31:0] cfgRdData,
    input wire logic [7:0] auxControl,
    output logic ioMemEnable,
    input wire logic intEvent,
    input wire logic legacyClear,
    output logic legacyIntPin,
    output logic msiValid,
    input wire logic msiReady,
    output pci_pm_msi_pkg::msi_wr_s msiWrite
);

    // ------------------------------------------------------------
    // State and next-state logic.
    // ------------------------------------------------------------
    pci_pm_msi_pkg::state_s st_ff;
    pci_pm_msi_pkg::state_s nxt_st;
    logic suppress;
    logic isWrite;
    logic softReset;
    logic powerOn;

    assign suppress = auxControl[pci_pm_msi_pkg::AUX_SUPPRESS_BIT];
    assign isWrite = cfgValid && cfgReq.write;
    assign powerOn = (st_ff.powerState == pci_pm_msi_pkg::POWER_D0);

    always_comb begin
        nxt_st = st_ff;
        softReset = 1'b0;
        nxt_st.ack = cfgValid;
        // Configuration accesses are answered in every power state.
        if (isWrite) begin
            case (cfgReq.addr)
                pci_pm_msi_pkg::POWER_MGMT_CTRL_STATUS_OFFSET: begin
                    if (cfgReq.byteEn[0] && (cfgReq.wrData[1:0] == pci_pm_msi_pkg::POWER_D0 ||
                        cfgReq.wrData[1:0] == pci_pm_msi_pkg::POWER_D3HOT)) begin
                        nxt_st.powerState = cfgReq.wrData[1:0];
                        softReset = (st_ff.powerState == pci_pm_msi_pkg::POWER_D3HOT) &&
                            (cfgReq.wrData[1:0] == pci_pm_msi_pkg::POWER_D0) &&
                            !suppress;
                    end
                end
                pci_pm_msi_pkg::CAP_HEADER_OFFSET: begin
                    if (cfgReq.byteEn[2]) begin
                        nxt_st.msgEnable = cfgReq.wrData[pci_pm_msi_pkg::MSG_ENABLE_BIT];
                        nxt_st.multiMsgEnable =
                            cfgReq.wrData[pci_pm_msi_pkg::MULTI_MSG_LSB +: 3];
                    end
                end
                pci_pm_msi_pkg::ADDR_LOW_OFFSET: begin
                    for (int b = 0; b < 4; b++) begin
                        if (cfgReq.byteEn[b]) begin
                            nxt_st.addrLow[8*b +: 8] = cfgReq.wrData[8*b +: 8];
                        end
                    end
                    nxt_st.addrLow[1:0] = 2'h0;
                end
                pci_pm_msi_pkg::ADDR_HIGH_OFFSET: begin
                    if (cfgReq.byteEn[0]) begin
                        nxt_st.addrHigh = cfgReq.wrData[3:0];
                    end
                end
                pci_pm_msi_pkg::MSG_DATA_OFFSET: begin
                    for (int b = 0; b < 2; b++) begin
                        if (cfgReq.byteEn[b]) begin
                            nxt_st.msgData[8*b +: 8] = cfgReq.wrData[8*b +: 8];
                        end
                    end
                end
                default: begin
                end
            endcase
        end
        // Read data is built from the current register values.
        nxt_st.rdData = 32'h0000_0000;
        if (cfgValid && !cfgReq.write) begin
            case (cfgReq.addr)
                pci_pm_msi_pkg::POWER_MGMT_CTRL_STATUS_OFFSET: begin
                    nxt_st.rdData[1:0] = st_ff.powerState;
                    nxt_st.rdData[pci_pm_msi_pkg::SOFT_RESET_SUPPRESS_BIT] = suppress;
                    nxt_st.rdData[pci_pm_msi_pkg::WAKE_ENABLE_BIT] = 1'b0;
                    nxt_st.rdData[pci_pm_msi_pkg::WAKE_STATUS_BIT] = 1'b0;
                end
                pci_pm_msi_pkg::CAP_HEADER_OFFSET: begin
                    nxt_st.rdData[7:0] = pci_pm_msi_pkg::CAPABILITY_IDENTIFIER;
                    nxt_st.rdData[15:8] = pci_pm_msi_pkg::NEXT_POINTER;
                    nxt_st.rdData[pci_pm_msi_pkg::WIDE_CAPABLE_BIT] = 1'b1;
                    nxt_st.rdData[pci_pm_msi_pkg::MULTI_MSG_LSB +: 3] = st_ff.multiMsgEnable;
                    nxt_st.rdData[pci_pm_msi_pkg::MSG_ENABLE_BIT] = st_ff.msgEnable;
                end
                pci_pm_msi_pkg::ADDR_LOW_OFFSET: begin
                    nxt_st.rdData = {st_ff.addrLow[31:2], 2'h0};
                end
                pci_pm_msi_pkg::ADDR_HIGH_OFFSET: begin
                    nxt_st.rdData[3:0] = st_ff.addrHigh;
                end
                pci_pm_msi_pkg::MSG_DATA_OFFSET: begin
                    nxt_st.rdData[15:0] = st_ff.msgData;
                end
                default: begin
                end
            endcase
        end
        // Interrupt events: blocked outside the on state, set wins over clear.
        if (legacyClear) begin
            nxt_st.legacyPending = 1'b0;
        end
        if (intEvent && powerOn) begin
            if (st_ff.msgEnable) begin
                nxt_st.msiPending = 1'b1;
            end else begin
                nxt_st.legacyPending = 1'b1;
            end
        end
        case (st_ff.msiState)
            pci_pm_msi_pkg::MSI_IDLE: begin
                if (st_ff.msiPending && st_ff.msgEnable && powerOn) begin
                    nxt_st.msiState = pci_pm_msi_pkg::MSI_SEND;
                    if (!(intEvent && powerOn && st_ff.msgEnable)) begin
                        nxt_st.msiPending = 1'b0;
                    end
                    nxt_st.msiOut.addr = {st_ff.addrHigh, st_ff.addrLow[31:2], 2'h0};
                    nxt_st.msiOut.data = {16'h0000, st_ff.msgData};
                    nxt_st.msiOut.wide = (st_ff.addrHigh != 4'h0);
                end
            end
            pci_pm_msi_pkg::MSI_SEND: begin
                if (msiReady) begin
                    nxt_st.msiState = pci_pm_msi_pkg::MSI_IDLE;
                end
            end
            default: begin
                nxt_st.msiState = pci_pm_msi_pkg::MSI_IDLE;
            end
        endcase
        // Internal soft reset restores the message registers.
        if (softReset) begin
            nxt_st.msgEnable = pci_pm_msi_pkg::MSG_CONTROL_RESET[0];
            nxt_st.multiMsgEnable = pci_pm_msi_pkg::MULTI_MSG_RESET;
            nxt_st.addrLow = pci_pm_msi_pkg::ADDR_LOW_RESET;
            nxt_st.addrHigh = pci_pm_msi_pkg::ADDR_HIGH_RESET;
            nxt_st.msgData = pci_pm_msi_pkg::MSG_DATA_RESET;
            nxt_st.msiPending = 1'b0;
            nxt_st.legacyPending = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            st_ff <= '0;
            st_ff.powerState <= pci_pm_msi_pkg::POWER_D0;
            st_ff.addrLow <= pci_pm_msi_pkg::ADDR_LOW_RESET;
            st_ff.msgData <= pci_pm_msi_pkg::MSG_DATA_RESET;
            st_ff.msiState <= pci_pm_msi_pkg::MSI_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs.
    // ------------------------------------------------------------
    assign cfgAck = st_ff.ack;
    assign cfgRdData = st_ff.rdData;
    assign ioMemEnable = powerOn;
    assign legacyIntPin = st_ff.legacyPending && !st_ff.msgEnable && powerOn;
    assign msiValid = (st_ff.msiState == pci_pm_msi_pkg::MSI_SEND);
    assign msiWrite = st_ff.msiOut;

    // ------------------------------------------------------------
    // Assertions.
    // ------------------------------------------------------------
    bad_state_drop_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        isWrite && cfgReq.addr == pci_pm_msi_pkg::POWER_MGMT_CTRL_STATUS_OFFSET && cfgReq.byteEn[0] &&
        (cfgReq.wrData[1:0] == 2'h1 || cfgReq.wrData[1:0] == 2'h2)
        |=> $stable(st_ff.powerState))
        else $error("Reserved power state code was stored.");
    lowpower_block_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        !powerOn |-> !ioMemEnable && !legacyIntPin)
        else $error("Access or interrupt allowed in low-power state.");
    keep_context_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        isWrite && cfgReq.addr == pci_pm_msi_pkg::POWER_MGMT_CTRL_STATUS_OFFSET && suppress &&
        !powerOn && cfgReq.byteEn[0] && cfgReq.wrData[1:0] == 2'h0
        |=> $stable(st_ff.addrLow) && $stable(st_ff.msgData))
        else $error("Context lost with soft reset suppressed.");
    soft_reset_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        isWrite && cfgReq.addr == pci_pm_msi_pkg::POWER_MGMT_CTRL_STATUS_OFFSET && !suppress &&
        !powerOn && cfgReq.byteEn[0] && cfgReq.wrData[1:0] == 2'h0
        |=> st_ff.addrLow == 32'h0 && st_ff.msgData == 16'h0 && !st_ff.msgEnable)
        else $error("Soft reset did not clear message registers.");
    header_read_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        cfgValid && !cfgReq.write && cfgReq.addr == pci_pm_msi_pkg::CAP_HEADER_OFFSET
        |=> cfgAck && cfgRdData[15:0] == 16'h0005 && cfgRdData[23] && cfgRdData[19:17] == 3'h0)
        else $error("Capability header or control read wrong.");
    wake_bits_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        cfgValid && !cfgReq.write && cfgReq.addr == pci_pm_msi_pkg::POWER_MGMT_CTRL_STATUS_OFFSET
        |=> cfgRdData[15] == 1'b0 && cfgRdData[8] == 1'b0 && cfgRdData[3] == $past(suppress))
        else $error("Power control status read wrong.");
    msi_content_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        $rose(msiValid) |-> msiWrite.addr[1:0] == 2'h0 && msiWrite.data[31:16] == 16'h0 &&
        msiWrite.data[15:0] == $past(st_ff.msgData) &&
        msiWrite.wide == (msiWrite.addr[35:32] != 4'h0))
        else $error("Message write content wrong.");
    msi_launch_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        intEvent && powerOn && st_ff.msgEnable && !msiValid && !st_ff.msiPending
        |=> ##1 msiValid)
        else $error("Enabled event did not launch a message.");
    legacy_quiet_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        st_ff.msgEnable |-> !legacyIntPin)
        else $error("Legacy pin used with message interrupts enabled.");
    addr_align_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        st_ff.addrLow[1:0] == 2'h0)
        else $error("Low address not dword aligned.");

endmodule : pci_pm_msi_capability

/* pci_pm_msi_pkg.sv */
/*
 * Constants, field layouts and carrier types for the power management
 * control/status and message interrupt configuration block.
 * Assumes dword-aligned configuration byte addresses with byte enables.
 */
package pci_pm_msi_pkg;

    // ------------------------------------------------------------
    // Register offsets (configuration byte addresses).
    // ------------------------------------------------------------
    localparam logic [7:0] POWER_MGMT_CTRL_STATUS_OFFSET = 8'hCC;
    localparam logic [7:0] CAP_HEADER_OFFSET = 8'hD0;
    localparam logic [7:0] MSG_CONTROL_OFFSET = 8'hD2;
    localparam logic [7:0] ADDR_LOW_OFFSET = 8'hD4;
    localparam logic [7:0] ADDR_HIGH_OFFSET = 8'hD8;
    localparam logic [7:0] MSG_DATA_OFFSET = 8'hDC;

    // ------------------------------------------------------------
    // Field values and positions.
    // ------------------------------------------------------------
    localparam logic [1:0] POWER_D0 = 2'h0;
    localparam logic [1:0] POWER_D3HOT = 2'h3;
    localparam int SOFT_RESET_SUPPRESS_BIT = 3;
    localparam int AUX_SUPPRESS_BIT = 6;
    localparam int WAKE_ENABLE_BIT = 8;
    localparam int WAKE_STATUS_BIT = 15;
    localparam logic [7:0] CAPABILITY_IDENTIFIER = 8'h05;
    localparam logic [7:0] NEXT_POINTER = 8'h00;
    localparam int MSG_ENABLE_BIT = 16;
    localparam int MULTI_MSG_LSB = 20;
    localparam int WIDE_CAPABLE_BIT = 23;
    localparam logic [15:0] MSG_CONTROL_RESET = 16'h0080;
    localparam logic [31:0] ADDR_LOW_RESET = 32'h0000_0000;
    localparam logic [3:0] ADDR_HIGH_RESET = 4'h0;
    localparam logic [15:0] MSG_DATA_RESET = 16'h0000;
    localparam logic [2:0] MULTI_MSG_RESET = 3'h0;

    // ------------------------------------------------------------
    // Types.
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MSI_IDLE = 2'b01,
        MSI_SEND = 2'b10
    } msi_state_e;

    typedef struct packed {
        logic write;
        logic [7:0] addr;
        logic [3:0] byteEn;
        logic [31:0] wrData;
    } cfg_req_s;

    typedef struct packed {
        logic [35:0] addr;
        logic [31:0] data;
        logic wide;
    } msi_wr_s;

    typedef struct packed {
        logic [1:0] powerState;
        logic [2:0] multiMsgEnable;
        logic msgEnable;
        logic [31:0] addrLow;
        logic [3:0] addrHigh;
        logic [15:0] msgData;
        logic [31:0] rdData;
        logic ack;
        logic msiPending;
        logic legacyPending;
        msi_state_e msiState;
        msi_wr_s msiOut;
    } state_s;

endpackage : pci_pm_msi_pkg

/* test_pci_pm_msi_capability.sv */
/*
 * Self-checking bench of the power state and message interrupt block.
 * Assumes the design package and the msi_sink model are compiled first.
 */
`timescale 1ns/100ps
module test_pci_pm_msi_capability;
    // ------------------------------------------------------------
    // Signals, design and fabric model.
    // ------------------------------------------------------------
    logic ref_clk = 1'b0, reset_n = 1'b0, cfgValid = 1'b0, cfgAck, ioMemEnable;
    logic intEvent = 1'b0, legacyClear = 1'b0, legacyIntPin, msiValid, msiReady;
    logic [7:0] auxControl = 8'h00;
    logic [3:0] stall = 4'h3;
    logic [31:0] cfgRdData, rd;
    pci_pm_msi_pkg::cfg_req_s cfgReq = '0;
    pci_pm_msi_pkg::msi_wr_s msiWrite, lastWrite;
    int count, errors = 0, nTests = 0;
    logic [43:0] rows [25] = '{44'h0CC00000000, 44'h0D000800005, 44'h0D400000000,
        44'h1D0FFFFFFFF, 44'h0D000F10005, 44'h1D4FFFFFFFF, 44'h0D4FFFFFFFC,
        44'h1D8FFFFFFFF, 44'h0D80000000F, 44'h1DCFFFFFFFF, 44'h0DC0000FFFF,
        44'h1CCFFFFFFFF, 44'h0CC00000003, 44'h1CC00000001, 44'h0CC00000003,
        44'h1CC00000002, 44'h0CC00000003, 44'h1E0FFFFFFFF, 44'h0E000000000,
        44'h1CC00000000, 44'h0CC00000000, 44'h0D000800005, 44'h0D400000000,
        44'h0D800000000, 44'h0DC00000000};

    pci_pm_msi_capability i_pci_pm_msi_capability (.ref_clk(ref_clk), .reset_n(reset_n),
        .cfgValid(cfgValid), .cfgReq(cfgReq), .cfgAck(cfgAck), .cfgRdData(cfgRdData),
        .auxControl(auxControl), .ioMemEnable(ioMemEnable), .intEvent(intEvent),
        .legacyClear(legacyClear), .legacyIntPin(legacyIntPin), .msiValid(msiValid),
        .msiReady(msiReady), .msiWrite(msiWrite));
    msi_sink i_msi_sink (.ref_clk(ref_clk), .reset_n(reset_n), .msiValid(msiValid),
        .msiWrite(msiWrite), .stall(stall), .msiReady(msiReady), .count(count),
        .lastWrite(lastWrite));

    initial begin
        forever #12.5 ref_clk = ~ref_clk;
    end

    // ------------------------------------------------------------
    // Tasks.
    // ------------------------------------------------------------
    task automatic print_verdict;
        if (errors == 0 && nTests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [68:0] got, input logic [68:0] exp);
        nTests++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic cfg(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(negedge ref_clk);
        cfgValid = 1'b1;
        cfgReq = '{write: w, addr: a, byteEn: 4'hF, wrData: d};
        @(negedge ref_clk);
        cfgValid = 1'b0;
        chk(69'(cfgAck), 69'h1);
        rd = cfgRdData;
    endtask : cfg

    task automatic pulse(input bit clr);
        @(negedge ref_clk);
        if (clr) legacyClear = 1'b1; else intEvent = 1'b1;
        @(negedge ref_clk);
        legacyClear = 1'b0;
        intEvent = 1'b0;
    endtask : pulse

    task automatic wait_cnt(input int n);
        for (int i = 0; i < 60 && count < n; i++) @(negedge ref_clk);
        if (count < n) begin
            errors++;
            print_verdict();
        end
    endtask : wait_cnt

    // ------------------------------------------------------------
    // Main sequence.
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(negedge ref_clk);
        reset_n = 1'b1;
        chk(69'({ioMemEnable, legacyIntPin, msiValid, cfgAck}), 69'h8);
        foreach (rows[i]) begin
            cfg(rows[i][40], rows[i][39:32], rows[i][31:0]);
            if (!rows[i][40]) chk(69'(rd), 69'(rows[i][31:0]));
        end
        pulse(1'b0);
        @(negedge ref_clk);
        chk(69'({legacyIntPin, msiValid}), 69'h2);
        pulse(1'b1);
        chk(69'(legacyIntPin), 69'h0);
        cfg(1'b1, 8'hD4, 32'h1234567B);
        cfg(1'b1, 8'hDC, 32'hFFFFBEEF);
        cfg(1'b1, 8'hD0, 32'h00710000);
        pulse(1'b0);
        wait_cnt(1);
        chk(69'(lastWrite), {36'h012345678, 32'h0000BEEF, 1'b0});
        chk(69'(legacyIntPin), 69'h0);
        stall = 4'h6;
        cfg(1'b1, 8'hD8, 32'hFFFFFFFA);
        pulse(1'b0);
        @(negedge ref_clk);
        pulse(1'b0);
        pulse(1'b0);
        wait_cnt(3);
        repeat (12) @(negedge ref_clk);
        chk(69'(count), 69'h3);
        chk(69'(lastWrite), {36'hA12345678, 32'h0000BEEF, 1'b1});
        cfg(1'b1, 8'hCC, 32'h00000003);
        chk(69'(ioMemEnable), 69'h0);
        pulse(1'b0);
        repeat (8) @(negedge ref_clk);
        chk(69'({count[3:0], legacyIntPin, msiValid}), 69'hC);
        auxControl = 8'h40;
        cfg(1'b0, 8'hCC, 32'h0);
        chk(69'(rd), 69'h0000000B);
        cfg(1'b1, 8'hCC, 32'h00000000);
        cfg(1'b0, 8'hD4, 32'h0);
        chk(69'(rd), 69'h12345678);
        cfg(1'b0, 8'hD0, 32'h0);
        chk(69'({ioMemEnable, rd}), 69'h100F10005);
        reset_n = 1'b0;
        repeat (2) @(negedge ref_clk);
        reset_n = 1'b1;
        cfg(1'b0, 8'hD8, 32'h0);
        chk(69'(rd), 69'h0);
        cfg(1'b0, 8'hD0, 32'h0);
        chk(69'(rd), 69'h00800005);
        print_verdict();
    end
endmodule : test_pci_pm_msi_capability
